// [shared/chgsr_defines.svh]
`ifndef CHGSR_DEFINES_SVH
`define CHGSR_DEFINES_SVH
// Register indices on the serial register port
`define CHGSR_ADDR_STATUS      8'h0B
`define CHGSR_ADDR_FAULT       8'h0C
`define CHGSR_ADDR_VLIMIT      8'h0D
// Source status field positions
`define CHGSR_SRC_MSB          7
`define CHGSR_SRC_LSB          5
`define CHGSR_CHG_MSB          4
`define CHGSR_CHG_LSB          3
`define CHGSR_PG_BIT           2
`define CHGSR_RSV_BIT          1
`define CHGSR_SYSMIN_BIT       0
// Fault field positions
`define CHGSR_WDOG_BIT         7
`define CHGSR_BOOST_BIT        6
`define CHGSR_CFLT_MSB         5
`define CHGSR_CFLT_LSB         4
`define CHGSR_BOVP_BIT         3
`define CHGSR_NTC_MSB          2
`define CHGSR_NTC_LSB          0
// Limit register layout and values; reserved status bit value
`define CHGSR_ABS_BIT          7
`define CHGSR_VLIMIT_RESET     8'h12
`define CHGSR_CODE_FLOOR       7'h0D
`define CHGSR_RSV_VALUE        1'h1
// Threshold scale in millivolts
`define CHGSR_OFFSET_MV        2600
`define CHGSR_STEP_MV          100
`endif

// [shared/chgsr_pkg.sv]
package chgsr_pkg;
  // Detected input source
  typedef enum logic [2:0] {
    CHGSR_SRC_NONE    = 3'h0,
    CHGSR_SRC_USB_SDP = 3'h1,
    CHGSR_SRC_ADAPTER = 3'h2,
    CHGSR_SRC_OTG     = 3'h7
  } chgsr_source_type;
  // Charging progress
  typedef enum logic [1:0] {
    CHGSR_CHG_IDLE = 2'h0,
    CHGSR_CHG_PRE  = 2'h1,
    CHGSR_CHG_FAST = 2'h2,
    CHGSR_CHG_DONE = 2'h3
  } chgsr_progress_type;
  // Charging fault code
  typedef enum logic [1:0] {
    CHGSR_CFLT_NONE    = 2'h0,
    CHGSR_CFLT_INPUT   = 2'h1,
    CHGSR_CFLT_THERMAL = 2'h2,
    CHGSR_CFLT_TIMER   = 2'h3
  } chgsr_cfault_type;
endpackage : chgsr_pkg

// [design/chgsr_sync.sv]
`timescale 1ns/100ps
// Three-flop input conditioner: output moves once stages two and three agree
module chgsr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Raw and conditioned level
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] clean_out
);
  logic [WIDTH-1:0] stage1;   // Metastability catcher, read only by stage2
  logic [WIDTH-1:0] stage2;   // Second stage
  logic [WIDTH-1:0] stage3;   // Third stage

  // Shift chain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= raw_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per bit: accept a change only when two stages agree, filtering one-cycle glitches
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          clean_out[gi] <= 1'b0;
        end else if (stage2[gi] == stage3[gi]) begin
          clean_out[gi] <= stage3[gi];
        end
      end
    end
  endgenerate
endmodule : chgsr_sync

// [design/chgsr_regs.sv]
`timescale 1ns/100ps
`include "chgsr_defines.svh"
// Overview of operation
// - Bits 7:5 report detected input source
// - Bits 4:3 report charging progress
// - Reserved status bit 1 reads one
// - Bit 0 flags minimum system rail regulation
// - Fault bit 7 flags watchdog expiry
// - Fault bit 6 flags boost mode faults
// - Fault bits 5:4 encode charging fault
// - Limit bit 7 selects absolute tracking
// - Input plug-in restores limit register default
// - Code means 2.6V plus 100mV steps
// - Codes below 0001101 act as 3.9V
// - Relative mode: host code writes ignored, internal update
// - Absolute mode: host writes code, value kept
module chgsr_regs (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Register-reset control from the wider register map
  input  wire logic                     reg_reset,
  // Register port from the serial interface engine
  input  wire logic [7:0]               reg_addr,
  input  wire logic                     reg_wr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  // Charger condition inputs (from analog side, asynchronous)
  input  wire chgsr_pkg::chgsr_source_type   input_source_type,
  input  wire chgsr_pkg::chgsr_progress_type charge_progress,
  input  wire logic                     input_power_ok,
  input  wire logic                     sys_rail_min_reg_flag,
  input  wire logic                     watchdog_expired,
  input  wire logic                     boost_overload,
  input  wire logic                     boost_input_ovp,
  input  wire logic                     boost_battery_low,
  input  wire chgsr_pkg::chgsr_cfault_type   charging_fault_code,
  input  wire logic                     battery_overvoltage_flag,
  input  wire logic [2:0]               thermistor_fault_code,
  // Internally computed relative threshold code
  input  wire logic [6:0]               relative_limit_code,
  // Limit outputs to the regulation loop
  output logic                          absolute_threshold_select,
  output logic      [6:0]               input_voltage_limit_code,
  output logic      [6:0]               effective_limit_code,
  output logic      [13:0]              effective_limit_mv
);
  localparam int CondW = 20;       // Width of synchronised condition bus

  logic [CondW-1:0] cond_raw;      // Raw conditions packed for the conditioner
  logic [CondW-1:0] cond;          // Conditioned conditions
  logic             plugged_prev;  // Previous source-present state
  logic [7:0]       limit_reg;     // Stored limit register

  // Pack all asynchronous status inputs
  assign cond_raw = {input_source_type, charge_progress, input_power_ok,
                     sys_rail_min_reg_flag, watchdog_expired, boost_overload,
                     boost_input_ovp, boost_battery_low, charging_fault_code,
                     battery_overvoltage_flag, thermistor_fault_code,
                     relative_limit_code[2:0]};

  // Condition the pins; relative code top bits come from same-clock logic
  chgsr_sync #(.WIDTH(CondW)) u_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .raw_in    (cond_raw),
    .clean_out (cond)
  );

  // Field extraction
  wire [2:0] src_now      = cond[19:17];
  wire [1:0] prog_now     = cond[16:15];
  wire       pg_now       = cond[14];
  wire       sysmin_now   = cond[13];
  wire       wdog_now     = cond[12];
  wire       boost_now    = cond[11] | cond[10] | cond[9];
  wire [1:0] cflt_now     = cond[8:7];
  wire       bovp_now     = cond[6];
  wire [2:0] ntc_now      = cond[5:3];
  // Relative code lower bits are synchronised; same-clock upper bits need no conditioning
  wire [6:0] rel_code     = {relative_limit_code[6:3], cond[2:0]};

  // Live status images, assembled every cycle so a read sees current state
  wire [7:0] status_img;
  assign status_img[`CHGSR_SRC_MSB:`CHGSR_SRC_LSB] = src_now;
  assign status_img[`CHGSR_CHG_MSB:`CHGSR_CHG_LSB] = prog_now;
  assign status_img[`CHGSR_PG_BIT]                 = pg_now;
  assign status_img[`CHGSR_RSV_BIT]                = `CHGSR_RSV_VALUE;
  assign status_img[`CHGSR_SYSMIN_BIT]             = sysmin_now;
  wire [7:0] fault_img;
  assign fault_img[`CHGSR_WDOG_BIT]                = wdog_now;
  assign fault_img[`CHGSR_BOOST_BIT]               = boost_now;
  assign fault_img[`CHGSR_CFLT_MSB:`CHGSR_CFLT_LSB] = cflt_now;
  assign fault_img[`CHGSR_BOVP_BIT]                = bovp_now;
  assign fault_img[`CHGSR_NTC_MSB:`CHGSR_NTC_LSB]  = ntc_now;

  // Decode
  wire sel_status = (reg_addr == `CHGSR_ADDR_STATUS);
  wire sel_fault  = (reg_addr == `CHGSR_ADDR_FAULT);
  wire sel_limit  = (reg_addr == `CHGSR_ADDR_VLIMIT);
  wire wr_limit   = reg_wr & sel_limit;
  wire plugged    = (src_now != 3'h0) & (src_now != 3'h7);
  wire plug_in    = plugged & ~plugged_prev;
  wire abs_mode   = limit_reg[`CHGSR_ABS_BIT];

  // Next limit register: reset, plug-in, host write, or internal tracking
  logic [7:0] next_limit;
  always_comb begin
    next_limit = limit_reg;
    if (reg_reset || plug_in) begin
      next_limit = `CHGSR_VLIMIT_RESET;
    end else if (wr_limit) begin
      if (reg_wdata[`CHGSR_ABS_BIT]) begin
        next_limit = reg_wdata;
      end else begin
        next_limit = {1'b0, rel_code};
      end
    end else if (!abs_mode) begin
      next_limit = {1'b0, rel_code};
    end
  end

  // Clamp to floor then scale
  wire [6:0] code_now  = limit_reg[6:0];
  wire [6:0] code_clmp = (code_now < `CHGSR_CODE_FLOOR) ? `CHGSR_CODE_FLOOR : code_now;
  // Top code reaches 15300 mV, so the scale needs fourteen bits, not twelve
  wire [13:0] mv_now   = 14'(`CHGSR_OFFSET_MV) + 14'(code_clmp) * 14'(`CHGSR_STEP_MV);

  // Read data select; status registers ignore writes entirely
  wire [7:0] rdata_now = sel_status ? status_img :
                         sel_fault  ? fault_img  :
                         sel_limit  ? limit_reg  : 8'h00;

  // Limit storage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      limit_reg <= `CHGSR_VLIMIT_RESET;
    end else begin
      limit_reg <= next_limit;
    end
  end

  // Plug-in edge history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      plugged_prev <= 1'b0;
    end else begin
      plugged_prev <= plugged;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata                 <= 8'h00;
      absolute_threshold_select <= 1'b0;
      input_voltage_limit_code  <= 7'h12;
      effective_limit_code      <= 7'h12;
      effective_limit_mv        <= 14'h0000;
    end else begin
      reg_rdata                 <= rdata_now;
      absolute_threshold_select <= abs_mode;
      input_voltage_limit_code  <= code_now;
      effective_limit_code      <= code_clmp;
      effective_limit_mv        <= mv_now;
    end
  end

  // Assertions
  rsv_bit_one_a: assert property (@(posedge sys_clk) disable iff (rst)
    sel_status |=> reg_rdata[1]) else $error("reserved bit not one");
  src_field_a: assert property (@(posedge sys_clk) disable iff (rst)
    sel_status |=> reg_rdata[7:5] == $past(src_now)) else $error("source field wrong");
  prog_field_a: assert property (@(posedge sys_clk) disable iff (rst)
    sel_status |=> reg_rdata[4:3] == $past(prog_now)) else $error("progress field wrong");
  sysmin_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    sel_status |=> reg_rdata[0] == $past(sysmin_now)) else $error("sysmin bit wrong");
  wdog_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    sel_fault |=> reg_rdata[7] == $past(wdog_now)) else $error("watchdog bit wrong");
  boost_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (sel_fault && cond[10]) |=> reg_rdata[6]) else $error("boost fault missed");
  cflt_field_a: assert property (@(posedge sys_clk) disable iff (rst)
    sel_fault |=> reg_rdata[5:4] == $past(cflt_now)) else $error("charge fault wrong");
  plug_default_a: assert property (@(posedge sys_clk) disable iff (rst)
    plug_in |=> limit_reg == 8'h12) else $error("plug-in did not restore");
  rel_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!abs_mode && !plug_in && !reg_reset && !(wr_limit && reg_wdata[7]))
    |=> limit_reg == {1'b0, $past(rel_code)}) else $error("relative code not tracked");
  abs_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_limit && reg_wdata[7] && !plug_in && !reg_reset) ##1 (!wr_limit && !plug_in && !reg_reset)[*2]
    |-> limit_reg == $past(reg_wdata, 2)) else $error("absolute code lost");
  floor_clamp_a: assert property (@(posedge sys_clk) disable iff (rst)
    (code_now < 7'h0D) |=> effective_limit_code == 7'h0D) else $error("floor not applied");
  mv_scale_a: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> effective_limit_mv == 14'(2600 + 100 * int'($past(code_clmp)))) else $error("scale wrong");
  abs_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> absolute_threshold_select == $past(limit_reg[7])) else $error("select mismatch");

  // Main scenarios
  plug_seen_c:   cover property (@(posedge sys_clk) disable iff (rst) plug_in);
  abs_write_c:   cover property (@(posedge sys_clk) disable iff (rst) wr_limit && reg_wdata[7]);
  fault_read_c:  cover property (@(posedge sys_clk) disable iff (rst) sel_fault && wdog_now);
  clamp_c:       cover property (@(posedge sys_clk) disable iff (rst) abs_mode && code_now < 7'h0D);
endmodule : chgsr_regs

// [tb/chgsr_host.sv]
`timescale 1ns/100ps
// Host side of the register port; every change lands 1 ns after an edge
module chgsr_host (
  // Clock
  input  wire logic       sys_clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle port before the first request
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'hFF;
  end
  // One-cycle strobe; released data shows its inverse so stale bytes never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr  = a;
    reg_wr    = 1'b1;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // Address held two edges so the registered answer has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    repeat (2) @(posedge sys_clk);
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : chgsr_host

// [tb/tb_charger_status_and_input_limit_regs.sv]
`timescale 1ns/100ps
module tb_charger_status_and_input_limit_regs;
  // Clock, reset and register port
  logic                          sys_clk = 1'b0;
  logic                          rst = 1'b1;
  logic                          reg_reset = 1'b0;
  logic [7:0]                    reg_addr, reg_wdata, reg_rdata, rd;
  logic                          reg_wr;
  // Charger conditions
  chgsr_pkg::chgsr_source_type   src = chgsr_pkg::CHGSR_SRC_NONE;
  chgsr_pkg::chgsr_progress_type prog = chgsr_pkg::CHGSR_CHG_IDLE;
  chgsr_pkg::chgsr_cfault_type   cflt = chgsr_pkg::CHGSR_CFLT_NONE;
  logic                          pg = 0, sysmin = 0, wd = 0, bo = 0, bi = 0, bl = 0, bovp = 0;
  logic [2:0]                    ntc = 3'h0;
  logic [6:0]                    rel = 7'h12;
  // Limit outputs
  logic                          abs_sel;
  logic [6:0]                    code, eff;
  logic [13:0]                   mv;
  int                            n_errors = 0, compares = 0, cycles = 0;

  always #25 sys_clk = ~sys_clk;

  chgsr_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  chgsr_regs uut (.sys_clk(sys_clk), .rst(rst), .reg_reset(reg_reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .input_source_type(src),
    .charge_progress(prog), .input_power_ok(pg), .sys_rail_min_reg_flag(sysmin),
    .watchdog_expired(wd), .boost_overload(bo), .boost_input_ovp(bi), .boost_battery_low(bl),
    .charging_fault_code(cflt), .battery_overvoltage_flag(bovp), .thermistor_fault_code(ntc),
    .relative_limit_code(rel), .absolute_threshold_select(abs_sel),
    .input_voltage_limit_code(code), .effective_limit_code(eff), .effective_limit_mv(mv));

  task automatic results;
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // Inputs pass a three-flop conditioner, so give them time to reach status
  task automatic settle;
    repeat (6) @(posedge sys_clk);
  endtask : settle

  // Relative code low bits pass the conditioner, so let them arrive first
  task automatic t_reset;
    settle;
    host.rd(8'h0E, rd);
    check(16'(rd), 16'h0000);
    host.rd(8'h0D, rd);
    check(16'(rd), 16'h0012);
    host.rd(8'h0B, rd);
    check(16'(rd), 16'h0002);
  endtask : t_reset

  task automatic t_status;
    logic [2:0] s [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    for (int i = 0; i < 4; i++) begin
      #1;
      src = chgsr_pkg::chgsr_source_type'(s[i]);
      prog = chgsr_pkg::chgsr_progress_type'(i[1:0]);
      pg = i[0];
      sysmin = ~i[0];
      settle;
      host.rd(8'h0B, rd);
      check(16'(rd), 16'({s[i], i[1:0], i[0], 1'b1, ~i[0]}));
    end
    host.wr(8'h0B, 8'h00);
    host.rd(8'h0B, rd);
    check(16'(rd), 16'h00FE);
  endtask : t_status

  // Each boost cause alone; ends with every fault cleared
  task automatic t_fault;
    for (int i = 3; i >= 0; i--) begin
      #1;
      cflt = chgsr_pkg::chgsr_cfault_type'(i[1:0]);
      wd = i[0];
      bo = (i == 1);
      bi = (i == 2);
      bl = (i == 3);
      bovp = i[1];
      ntc = i[2:0];
      settle;
      host.wr(8'h0C, 8'hFF);
      host.rd(8'h0C, rd);
      check(16'(rd), 16'({i[0], i != 0, i[1:0], i[1], i[2:0]}));
    end
  endtask : t_fault

  // Codes around the floor and the top end
  task automatic t_abs;
    logic [6:0] c [4] = '{7'h00, 7'h0C, 7'h0D, 7'h7F};
    logic [6:0] e;
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h0D, {1'b1, c[i]});
      host.rd(8'h0D, rd);
      e = (c[i] < 7'h0D) ? 7'h0D : c[i];
      check(16'(rd), 16'({1'b1, c[i]}));
      check(16'(code), 16'(c[i]));
      check(16'(abs_sel), 16'h0001);
      check(16'(eff), 16'(e));
      check(16'(mv), 16'(2600 + 100 * e));
    end
  endtask : t_abs

  task automatic t_rel;
    #1;
    rel = 7'h33;
    host.wr(8'h0D, 8'h05);
    settle;
    host.rd(8'h0D, rd);
    check(16'(rd), 16'h0033);
    check(16'(abs_sel), 16'h0000);
  endtask : t_rel

  // Plug-in and register-reset both bring back the default
  task automatic t_plug;
    #1;
    rel = 7'h12;
    src = chgsr_pkg::CHGSR_SRC_NONE;
    settle;
    host.wr(8'h0D, 8'h95);
    #1;
    src = chgsr_pkg::CHGSR_SRC_ADAPTER;
    settle;
    host.rd(8'h0D, rd);
    check(16'(rd), 16'h0012);
    host.wr(8'h0D, 8'hA0);
    reg_reset = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_reset = 1'b0;
    host.rd(8'h0D, rd);
    check(16'(rd), 16'h0012);
  endtask : t_plug

  // Hang guard well beyond the roughly 160 cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results;
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_status;
    t_fault;
    t_abs;
    t_rel;
    t_plug;
    results;
  end
endmodule : tb_charger_status_and_input_limit_regs
